// ---- bench/tap_asdu_packer_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"
module tap_asdu_packer_tb_top;
    import tap_pkg::*;
    // One buffered object as the reference model sees it.
    typedef struct {logic [7:0] typ; logic [5:0] cs; logic [7:0] len; logic [31:0] dat;} tap_obj_t;
    localparam logic [7:0] ORIG = 8'h5a;
    logic             sys_clk_i = 1'b0;
    logic             rst_b_i = 1'b0;
    logic [8:0]       max_asdu_len_i = 9'd34;
    logic [1:0]       buf_valid_i = '0, buf_tagged_i = '1, buf_older_i = '0, buf_ovf_i = '0;
    logic [1:0]       buf_ready_o;
    logic [1:0][7:0]  buf_type_i = '0, buf_len_i = '0, buf_orig_i = {2{ORIG}};
    logic [1:0][5:0]  buf_cause_i = '0;
    logic [1:0][31:0] buf_data_i = '0;
    logic             mirr_valid_i = 1'b0, mirr_neg_i = 1'b0, mirr_ready_o;
    logic [7:0]       mirr_type_i = '0, mirr_orig_i = ORIG;
    logic [5:0]       mirr_cause_i = '0;
    logic [6:0]       mirr_count_i = 7'h01;
    tap_mreason_t     mirr_reason_i = TAP_MR_NONE;
    logic             out_valid_o, out_ready_i, out_hdr_o, orig_en_o;
    logic [31:0]      out_data_o, s_axi_wdata_i = '0, s_axi_rdata_o;
    logic [7:0]       s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [3:0]       s_axi_wstrb_i = 4'hf;
    logic             s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic             s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic             s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic             s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]       s_axi_bresp_o, s_axi_rresp_o;
    logic             tst = 1'b0, oen = 1'b0;
    logic [5:0]       cl[12] = '{1, 2, 3, 5, 11, 12, 20, 36, 37, 41, 6, 42};
    int               errors = 0, n_checks = 0, n_drop, n_rdy = 0, n_ref_drop = 0, n_hdr = 0;
    tap_obj_t         bq[2][$], s0[$], s1[$];
    logic [32:0]      exp_q[$];

    // Free-running system clock.
    initial forever #10 sys_clk_i = ~sys_clk_i;

    tap_asdu_packer #(.NPRIO(2), .AW(8)) i_dut (
        .sys_clk_i, .rst_b_i, .max_asdu_len_i, .buf_valid_i, .buf_ready_o, .buf_type_i,
        .buf_cause_i, .buf_orig_i, .buf_len_i, .buf_tagged_i, .buf_older_i, .buf_data_i,
        .buf_ovf_i, .mirr_valid_i, .mirr_ready_o, .mirr_type_i, .mirr_cause_i, .mirr_neg_i,
        .mirr_reason_i, .mirr_orig_i, .mirr_count_i, .out_valid_o, .out_ready_i, .out_hdr_o,
        .out_data_o, .orig_en_o, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);

    tap_ctl_station i_sta (.sys_clk_i, .rst_b_i, .valid_i(out_valid_o), .hdr_i(out_hdr_o),
        .data_i(out_data_o), .ready_o(out_ready_i), .n_drop_o(n_drop));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Heads advance on the edge that consumed them, so a buffer never looks empty mid-run.
    always @(posedge sys_clk_i) begin
        if (rst_b_i && out_valid_o && out_ready_i)
            chk({out_hdr_o, out_data_o}, exp_q.size() ? exp_q.pop_front() : 'x, "word");
        if (buf_ready_o[0] === 1'b1) n_rdy++;
        for (int n = 0; n < 2; n++) begin
            if (buf_ready_o[n] === 1'b1 && bq[n].size() != 0) void'(bq[n].pop_front());
            buf_valid_i[n] <= bq[n].size() != 0;
            if (bq[n].size() != 0) begin
                buf_type_i[n] <= bq[n][0].typ;
                buf_cause_i[n] <= bq[n][0].cs;
                buf_len_i[n] <= bq[n][0].len;
                buf_data_i[n] <= bq[n][0].dat;
            end
        end
    end

    function automatic logic [32:0] hw(logic [7:0] t, int c, logic [5:0] cs, logic neg);
        n_hdr++;
        return {1'b1, oen ? ORIG : 8'h00, tst, neg, cs, 1'b0, 7'(c), t};
    endfunction

    function automatic bit ok(tap_obj_t o);
        return o.cs inside {1, 2, 3, 5, 11, 12, [20:41]} && 4 + oen + o.len <= max_asdu_len_i;
    endfunction

    // Reference packer: closes a frame on type, cause, length or count limits.
    task automatic expect_run(input tap_obj_t s[$]);
        int cnt, oct;
        tap_obj_t cur;
        cnt = 0;
        oct = 0;
        foreach (s[i]) begin
            if (cnt > 0 && (s[i].typ != cur.typ || s[i].cs != cur.cs || !ok(s[i]) ||
                    oct + s[i].len > max_asdu_len_i || cnt == 127)) begin
                exp_q.push_back(hw(cur.typ, cnt, cur.cs, 1'b0));
                cnt = 0;
            end
            if (!ok(s[i])) n_ref_drop++;
            else begin
                if (cnt == 0) cur = s[i];
                if (cnt == 0) oct = 4 + oen;
                exp_q.push_back({1'b0, s[i].dat});
                cnt++;
                oct += s[i].len;
            end
        end
        if (cnt > 0) exp_q.push_back(hw(cur.typ, cnt, cur.cs, 1'b0));
    endtask

    task automatic add(input int n, input logic [7:0] t, input logic [5:0] c, input int k,
                       input logic [7:0] ln);
        tap_obj_t o;
        repeat (k) begin
            o = '{t, c, ln, $urandom};
            bq[n].push_back(o);
            if (n != 0) s1.push_back(o);
            else s0.push_back(o);
        end
    endtask

    task automatic go;
        expect_run(s0);
        expect_run(s1);
        s0.delete();
        s1.delete();
        for (int i = 0; i < 3000 && exp_q.size() + bq[0].size() + bq[1].size() > 0; i++)
            @(posedge sys_clk_i);
        chk(33'(exp_q.size()), 33'h0, "left over");
        repeat (4) @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge sys_clk_i);
            if (!ad && s_axi_awready_o === 1'b1) begin ad = 1; s_axi_awvalid_i <= 1'b0; end
            if (!wd && s_axi_wready_o === 1'b1) begin wd = 1; s_axi_wvalid_i <= 1'b0; end
        end
        do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        chk(33'(s_axi_bresp_o), 33'(`TAP_RESP_OKAY), "bresp");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        chk(33'(s_axi_rdata_o), 33'(d), "rdata");
        chk(33'(s_axi_rresp_o), 33'(r), "rresp");
        // Let an edge pass so a following read never re-raises rready in this step.
        @(posedge sys_clk_i);
    endtask

    // Mirror of a control unit; a nonzero reason forces negative polarity.
    task automatic mirror(input int r);
        mirr_type_i <= 8'(45 + r);
        mirr_cause_i <= 6'h07;
        mirr_reason_i <= tap_mreason_t'(r);
        mirr_valid_i <= 1'b1;
        exp_q.push_back(hw(8'(45 + r), 1, r != 0 ? 6'(43 + r) : 6'h07, r != 0));
        do @(posedge sys_clk_i); while (mirr_ready_o !== 1'b1);
        mirr_valid_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(82));
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(`TAP_REG_CTRL, 32'h1, `TAP_RESP_OKAY);
        add(0, 8'h01, 6'h03, 2, 4);
        add(0, 8'h02, 6'h03, 2, 4);
        add(0, 8'h01, 6'h03, 2, 4);
        go();
        add(0, 8'h01, 6'h03, 1, 4);
        add(0, 8'h01, 6'h14, 2, 4);
        add(0, 8'h0d, 6'h03, 7, 10);
        add(0, 8'h0d, 6'h03, 1, 31);
        go();
        foreach (cl[i]) add(0, 8'h01, cl[i], 1 + $urandom % 3, 4);
        go();
        add(0, 8'h01, 6'h03, 3, 4);
        add(1, 8'h01, 6'h03, 3, 4);
        go();
        wr(`TAP_REG_CTRL, 32'h7);
        tst = 1'b1;
        oen = 1'b1;
        chk(33'(orig_en_o), 33'h1, "orig_en");
        add(0, 8'h0d, 6'h05, 7, 10);
        go();
        for (int r = 0; r < 5; r++) mirror(r);
        // The station may stall the last mirror header for a while.
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge sys_clk_i);
        chk(33'(exp_q.size()), 33'h0, "mirror");
        buf_tagged_i <= 2'b10;
        buf_older_i <= 2'b01;
        add(0, 8'h01, 6'h03, 2, 4);
        n_rdy = 0;
        repeat (30) @(posedge sys_clk_i);
        chk(33'(n_rdy), 33'h0, "stalled head");
        buf_older_i <= 2'b00;
        go();
        buf_tagged_i <= 2'b11;
        buf_ovf_i <= 2'b10;
        @(posedge sys_clk_i);
        buf_ovf_i <= 2'b00;
        repeat (2) @(posedge sys_clk_i);
        rd(`TAP_REG_STATUS, {16'h0, 8'(n_ref_drop), 8'h01}, `TAP_RESP_OKAY);
        wr(`TAP_REG_STATUS, 32'h1);
        rd(`TAP_REG_STATUS, {16'h0, 8'(n_ref_drop), 8'h00}, `TAP_RESP_OKAY);
        rd(8'h0c, 32'h0, `TAP_RESP_SLVERR);
        rd(`TAP_REG_ASDUS, 32'(n_hdr), `TAP_RESP_OKAY);
        chk(33'(n_drop), 33'h0, "discarded");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- bench/tap_ctl_station.sv ----
`timescale 1ns/10ps
`default_nettype none
// Controlling station: takes stream words at a random pace, counts discarded headers.
module tap_ctl_station (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        valid_i,
    input  wire logic        hdr_i,
    input  wire logic [31:0] data_i,
    output logic             ready_o,
    output int               n_drop_o
);
    // Random stalls make the packer hold its words; about one cycle in four stalls.
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o  <= 1'b0;
            n_drop_o <= 0;
        end else begin
            ready_o <= ($urandom % 4) != 0;
            if (valid_i && ready_o && hdr_i && !(data_i[21:16] inside {[1:13], [20:41], [44:63]}))
                n_drop_o <= n_drop_o + 1;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/tap_asdu_packer.sv ----
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module tap_asdu_packer
    import tap_pkg::*;
#(
    parameter int NPRIO = 4,
    parameter int AW    = 8
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [8:0]             max_asdu_len_i,
    input  wire logic [NPRIO-1:0]       buf_valid_i,
    output logic      [NPRIO-1:0]       buf_ready_o,
    input  wire logic [NPRIO-1:0][7:0]  buf_type_i,
    input  wire logic [NPRIO-1:0][5:0]  buf_cause_i,
    input  wire logic [NPRIO-1:0][7:0]  buf_orig_i,
    input  wire logic [NPRIO-1:0][7:0]  buf_len_i,
    input  wire logic [NPRIO-1:0]       buf_tagged_i,
    input  wire logic [NPRIO-1:0]       buf_older_i,
    input  wire logic [NPRIO-1:0][31:0] buf_data_i,
    input  wire logic [NPRIO-1:0]       buf_ovf_i,
    input  wire logic                   mirr_valid_i,
    output logic                        mirr_ready_o,
    input  wire logic [7:0]             mirr_type_i,
    input  wire logic [5:0]             mirr_cause_i,
    input  wire logic                   mirr_neg_i,
    input  wire tap_mreason_t           mirr_reason_i,
    input  wire logic [7:0]             mirr_orig_i,
    input  wire logic [6:0]             mirr_count_i,
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output logic                        out_hdr_o,
    output logic      [31:0]            out_data_o,
    output logic                        orig_en_o,
    input  wire logic [AW-1:0]          s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic      [1:0]             s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [AW-1:0]          s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic      [31:0]            s_axi_rdata_o,
    output logic      [1:0]             s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i
);

    localparam int PW = (NPRIO > 1) ? $clog2(NPRIO) : 1;

    typedef struct packed {
        tap_state_t       st;
        logic [PW-1:0]    prio;
        logic [7:0]       typ;
        logic [5:0]       cause;
        logic [7:0]       orig;
        logic [6:0]       cnt;
        logic [8:0]       fill;
        logic             ov;
        tap_kind_t        okind;
        logic [31:0]      odata;
        logic [2:0]       ctrl;
        logic             ovf;
        logic [7:0]       drops;
        logic [15:0]      asdus;
        logic             aw_got;
        logic             w_got;
        logic [AW-1:0]    awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } tap_st_t;

    tap_st_t s_q;
    tap_st_t s_d;

    logic [NPRIO-1:0] elig;
    logic [PW-1:0]    pick;
    logic [PW-1:0]    sel;
    logic             take;
    logic             ofree;
    logic             h_ok;
    logic             mon_ok;
    logic [8:0]       base;
    logic [8:0]       fill_nx;
    logic             h_fits;
    logic [5:0]       hcause;
    logic             hneg;
    logic [7:0]       hcot;
    logic [7:0]       horig;

    // A head is eligible unless it lacks a time tag while an older version
    // of the same object still waits elsewhere; the buffer stays stalled.
    genvar gi;
    generate
        for (gi = 0; gi < NPRIO; gi++) begin : g_elig
            assign elig[gi] = buf_valid_i[gi]
                              & ~(~buf_tagged_i[gi] & buf_older_i[gi]);
        end
    endgenerate

    // Lowest index wins, so buffer zero is the most urgent class.
    always_comb begin
        pick = '0;
        for (int i = NPRIO - 1; i >= 0; i--) begin
            if (elig[i]) begin
                pick = PW'(i);
            end
        end
    end

    // While packing, only the buffer of the open ASDU is ever looked at.
    assign sel     = (s_q.st == TAP_ST_IDLE) ? pick : s_q.prio;
    assign ofree   = ~s_q.ov | out_ready_i;
    assign base    = `TAP_HDR_OCTETS + {8'h00, s_q.ctrl[`TAP_CTRL_ORIG]};
    assign fill_nx = ((s_q.st == TAP_ST_IDLE) ? base : s_q.fill) + {1'b0, buf_len_i[sel]};

    // Head check for the object under the cursor.
    tap_cot_enc u_head_chk (
        .cause_i  (buf_cause_i[sel]),
        .neg_i    (1'b0),
        .test_i   (1'b0),
        .cot_o    (),
        .mon_ok_o (mon_ok)
    );

    // The frame length is a system input, so a full frame simply closes.
    assign h_ok   = elig[sel] & mon_ok;
    assign h_fits = h_ok & (fill_nx <= max_asdu_len_i)
                  & (buf_type_i[sel] == s_q.typ)
                  & (buf_cause_i[sel] == s_q.cause)
                  & (buf_orig_i[sel] == s_q.orig)
                  & (s_q.cnt != `TAP_MAX_COUNT);

    // Mirrors for unknown fields take the fixed negative causes in order.
    always_comb begin
        hcause = s_q.cause;
        hneg   = 1'b0;
        horig  = s_q.orig;
        if (s_q.st == TAP_ST_IDLE) begin
            horig = mirr_orig_i;
            if (mirr_reason_i != TAP_MR_NONE) begin
                hcause = `TAP_CAUSE_UNK_TYP + {3'h0, mirr_reason_i} - 6'h01;
                hneg   = 1'b1;
            end else begin
                hcause = mirr_cause_i;
                hneg   = mirr_neg_i;
            end
        end
        if (!s_q.ctrl[`TAP_CTRL_ORIG]) begin
            horig = 8'h00;
        end
    end

    tap_cot_enc u_hdr_cot (
        .cause_i  (hcause),
        .neg_i    (hneg),
        .test_i   (s_q.ctrl[`TAP_CTRL_TEST]),
        .cot_o    (hcot),
        .mon_ok_o ()
    );

    // Next-state logic for the packer and the register slave.
    always_comb begin
        s_d          = s_q;
        take         = 1'b0;
        mirr_ready_o = 1'b0;
        if (out_ready_i) begin
            s_d.ov = 1'b0;
        end
        case (s_q.st)
            TAP_ST_IDLE: begin
                if (ofree && s_q.ctrl[`TAP_CTRL_EN]) begin
                    if (mirr_valid_i) begin
                        // Header word: type, qualifier, cause octet, originator.
                        mirr_ready_o = 1'b1;
                        s_d.ov       = 1'b1;
                        s_d.okind    = TAP_K_HDR;
                        s_d.odata    = {horig, hcot, 1'b0, mirr_count_i, mirr_type_i};
                        s_d.asdus    = s_q.asdus + 16'h0001;
                    end else if (|elig) begin
                        take = 1'b1;
                        if (!h_ok || (fill_nx > max_asdu_len_i)) begin
                            // Unusable objects are discarded and counted.
                            s_d.drops = s_q.drops + 8'h01;
                        end else begin
                            s_d.st    = TAP_ST_PACK;
                            s_d.prio  = sel;
                            s_d.typ   = buf_type_i[sel];
                            s_d.cause = buf_cause_i[sel];
                            s_d.orig  = buf_orig_i[sel];
                            s_d.cnt   = 7'h01;
                            s_d.fill  = fill_nx;
                            s_d.ov    = 1'b1;
                            s_d.okind = TAP_K_OBJ;
                            s_d.odata = buf_data_i[sel];
                        end
                    end
                end
            end
            TAP_ST_PACK: begin
                if (ofree) begin
                    s_d.ov = 1'b1;
                    if (h_fits) begin
                        take      = 1'b1;
                        s_d.cnt   = s_q.cnt + 7'h01;
                        s_d.fill  = fill_nx;
                        s_d.okind = TAP_K_OBJ;
                        s_d.odata = buf_data_i[sel];
                    end else begin
                        // Close at once: an empty or mismatching head never waits.
                        s_d.st    = TAP_ST_IDLE;
                        s_d.okind = TAP_K_HDR;
                        s_d.odata = {horig, hcot, 1'b0, s_q.cnt, s_q.typ};
                        s_d.asdus = s_q.asdus + 16'h0001;
                    end
                end
            end
            default: s_d.st = TAP_ST_IDLE;
        endcase

        // Write channel: address and data may arrive in either order.
        if (s_axi_awvalid_i && !s_q.aw_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !s_q.w_got && !s_q.bvalid) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata_i;
            s_d.wstrb = s_axi_wstrb_i;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `TAP_RESP_OKAY;
            if (s_q.awaddr == `TAP_REG_CTRL) begin
                if (s_q.wstrb[0]) begin
                    s_d.ctrl = s_q.wdata[2:0];
                end
            end else if (s_q.awaddr == `TAP_REG_STATUS) begin
                if (s_q.wstrb[0] && s_q.wdata[`TAP_STAT_OVF]) begin
                    s_d.ovf = 1'b0;
                end
            end else if (s_q.awaddr != `TAP_REG_ASDUS) begin
                s_d.bresp = `TAP_RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready_i) begin
            s_d.bvalid = 1'b0;
        end

        // Read channel: one read at a time, answered the cycle after.
        if (s_q.rvalid && s_axi_rready_i) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = `TAP_RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (s_axi_araddr_i == `TAP_REG_CTRL) begin
                s_d.rdata[2:0] = s_q.ctrl;
            end else if (s_axi_araddr_i == `TAP_REG_STATUS) begin
                s_d.rdata = {16'h0000, s_q.drops, 7'h00, s_q.ovf};
            end else if (s_axi_araddr_i == `TAP_REG_ASDUS) begin
                s_d.rdata = {16'h0000, s_q.asdus};
            end else begin
                s_d.rresp = `TAP_RESP_SLVERR;
            end
        end

        // Overflow is applied last so a new event beats a clear.
        if (|buf_ovf_i) begin
            s_d.ovf = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q      <= '0;
            s_q.ctrl <= `TAP_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Ready goes only to the buffer whose head is consumed.
    always_comb begin
        buf_ready_o = '0;
        if (take) begin
            buf_ready_o[sel] = 1'b1;
        end
    end

    assign out_valid_o     = s_q.ov;
    assign out_hdr_o       = (s_q.okind == TAP_K_HDR);
    assign out_data_o      = s_q.odata;
    assign orig_en_o       = s_q.ctrl[`TAP_CTRL_ORIG];
    assign s_axi_awready_o = ~s_q.aw_got & ~s_q.bvalid;
    assign s_axi_wready_o  = ~s_q.w_got & ~s_q.bvalid;
    assign s_axi_bvalid_o  = s_q.bvalid;
    assign s_axi_bresp_o   = s_q.bresp;
    assign s_axi_arready_o = ~s_q.rvalid;
    assign s_axi_rvalid_o  = s_q.rvalid;
    assign s_axi_rdata_o   = s_q.rdata;
    assign s_axi_rresp_o   = s_q.rresp;

    // Helper: objects emitted since the last header. A mirror header can only
    // form right after a header was taken, so it always stands with this at zero.
    logic [7:0] seen_q;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_q <= 8'h00;
        end else if (s_q.ov && out_ready_i) begin
            seen_q <= (s_q.okind == TAP_K_HDR) ? 8'h00 : seen_q + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_group_type: assert property ((s_q.st == TAP_ST_PACK) && take |-> buf_type_i[sel] == s_q.typ && buf_cause_i[sel] == s_q.cause) else $error("mixed group in one ASDU");
    chk_prio_class: assert property ((s_q.st == TAP_ST_PACK) |-> (buf_ready_o & ~(NPRIO'(1) << s_q.prio)) == '0) else $error("object from another priority class");
    chk_fill_limit: assert property ((s_q.st == TAP_ST_PACK) |-> s_q.fill <= max_asdu_len_i) else $error("ASDU fill beyond maximum length");
    chk_no_wait: assert property ((s_q.st == TAP_ST_PACK) && ofree && !elig[s_q.prio] |=> s_q.ov && (s_q.okind == TAP_K_HDR) && (s_q.st == TAP_ST_IDLE)) else $error("ASDU held back waiting");
    chk_untagged_hold: assert property (|(buf_ready_o & ~buf_tagged_i & buf_older_i) == 1'b0) else $error("untagged object passed older version");
    chk_count_field: assert property (s_q.ov && (s_q.okind == TAP_K_HDR) && (seen_q != 8'h00) |-> s_q.odata[14:8] == seen_q[6:0]) else $error("object count field wrong");
    chk_cot_bits: assert property (s_q.ov && (s_q.okind == TAP_K_HDR) |-> s_q.odata[23] == s_q.ctrl[`TAP_CTRL_TEST] && s_q.odata[21:16] != 6'h00) else $error("cause octet malformed");
    chk_pn_zero: assert property (s_q.ov && (s_q.okind == TAP_K_HDR) && (seen_q != 8'h00) |-> !s_q.odata[22]) else $error("polarity set on monitored ASDU");
    chk_mirror_cause: assert property (mirr_ready_o && (mirr_reason_i != TAP_MR_NONE) |=> s_q.odata[22] && s_q.odata[21:16] >= 6'h2c && s_q.odata[21:16] <= 6'h2f) else $error("mirror cause not negative 44..47");
    chk_ovf_sticky: assert property ($rose(|buf_ovf_i) |=> s_q.ovf [*2]) else $error("overflow status not held");

    cov_full_pack: cover property ((s_q.st == TAP_ST_PACK) && (s_q.cnt > 7'h02) ##1 (s_q.okind == TAP_K_HDR));
    cov_mirror: cover property (mirr_valid_i && mirr_ready_o);
    cov_type_break: cover property ((s_q.st == TAP_ST_PACK) && elig[s_q.prio] && (buf_type_i[s_q.prio] != s_q.typ));

endmodule
`default_nettype wire

// ---- hdl/tap_cot_enc.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tap_regs.svh"

module tap_cot_enc
    import tap_pkg::*;
(
    input  wire logic [5:0] cause_i,
    input  wire logic       neg_i,
    input  wire logic       test_i,
    output logic      [7:0] cot_o,
    output logic            mon_ok_o
);

    // Cause in bits one to six, polarity in bit seven, test in bit eight.
    assign cot_o = {test_i, neg_i, cause_i};

    // Only the causes allowed for monitored objects pass; zero never does.
    always_comb begin
        mon_ok_o = (cause_i == `TAP_CAUSE_CYC) || (cause_i == `TAP_CAUSE_BACK)
                || (cause_i == `TAP_CAUSE_SPONT) || (cause_i == `TAP_CAUSE_REQ)
                || (cause_i == `TAP_CAUSE_RETREM) || (cause_i == `TAP_CAUSE_RETLOC)
                || ((cause_i >= `TAP_CAUSE_INRO) && (cause_i <= `TAP_CAUSE_RCO_HI));
    end

endmodule
`default_nettype wire

// ---- hdl/tap_pkg.sv ----
package tap_pkg;

    // Packer sequencing states.
    typedef enum logic [0:0] {
        TAP_ST_IDLE = 1'b0,
        TAP_ST_PACK = 1'b1
    } tap_state_t;

    // Kind of word on the output stream.
    typedef enum logic [0:0] {
        TAP_K_OBJ = 1'b0,
        TAP_K_HDR = 1'b1
    } tap_kind_t;

    // Reason for mirroring a control ASDU; zero is a plain confirmation.
    typedef enum logic [2:0] {
        TAP_MR_NONE = 3'h0,
        TAP_MR_TYPE = 3'h1,
        TAP_MR_CAUS = 3'h2,
        TAP_MR_CADR = 3'h3,
        TAP_MR_IOA  = 3'h4
    } tap_mreason_t;

endpackage

// ---- hdl/tap_regs.svh ----
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define TAP_REG_CTRL      8'h00
`define TAP_REG_STATUS    8'h04
`define TAP_REG_ASDUS     8'h08

// Control register fields and reset value.
`define TAP_CTRL_EN       0
`define TAP_CTRL_TEST     1
`define TAP_CTRL_ORIG     2
`define TAP_CTRL_RST      3'h1

// Status register fields.
`define TAP_STAT_OVF      0
`define TAP_STAT_DROP_LSB 8

// AXI responses.
`define TAP_RESP_OKAY     2'h0
`define TAP_RESP_SLVERR   2'h2

// Octets ahead of the objects: type, qualifier, cause, common address.
`define TAP_HDR_OCTETS    9'h004
`define TAP_MAX_COUNT     7'h7f

// Cause codes.
`define TAP_CAUSE_CYC     6'h01
`define TAP_CAUSE_BACK    6'h02
`define TAP_CAUSE_SPONT   6'h03
`define TAP_CAUSE_REQ     6'h05
`define TAP_CAUSE_RETREM  6'h0b
`define TAP_CAUSE_RETLOC  6'h0c
`define TAP_CAUSE_INRO    6'h14
`define TAP_CAUSE_INRO_HI 6'h24
`define TAP_CAUSE_REQCO   6'h25
`define TAP_CAUSE_RCO_HI  6'h29
`define TAP_CAUSE_UNK_TYP 6'h2c
`define TAP_CAUSE_PRIV    6'h30

`endif
